//--- core/pwp_pkg.sv
// Constants, field layouts and state types for the port wake and polling block.
//Contract
//RULE_01: Every reset clears all polling logic.
//RULE_02: Poll clock and period come from selectable taps.
//RULE_03: Software configures with enables clear, then starts.
//RULE_04: Software stops polling by clearing both enables.
//RULE_05: Restart needs enables set and reload rewritten.
//RULE_06: Wake flags and pin modes survive every reset.
//RULE_07: Per-pin trigger mode; disabled pins never request.
//RULE_08: Level sampled by strobe at window fall.
//RULE_09: Alternate strobe plus level keeps flag set.
//RULE_10: Software disables mode before clearing such flags.
//RULE_11: One strobe source serves every pin.
//RULE_12: Edge detection needs no strobe at all.
//RULE_13: Wake-up only when port wake enable set.
//RULE_14: Uncleared flags block further wake and interrupt.
//RULE_15: All pins share one interrupt request.
//RULE_16: Flags usable polled, as interrupt, as wake.
//RULE_17: Software uses alternate strobe for bus wake pins.
//RULE_18: Software sets poll pin as low output first.
//RULE_19: Flags clear by writing ones, whole register.
//RULE_20: Period tick loads counter, window high until zero.
//RULE_21: Pins synchronised before edge detection.
package pwp_pkg;
	localparam int PWP_NUM_PINS = 8;
	localparam int PWP_DW = 16;
	localparam int PWP_AW = 4;
	localparam int PWP_TAPS = 8;
	localparam int PWP_SYNC_W = 24;
	localparam int PWP_DEL_W = 8;
	// Register offsets.
	localparam logic [3:0] PWP_ADDR_POL_CTRL = 4'h0;
	localparam logic [3:0] PWP_ADDR_DELAY_RELOAD_VALUE = 4'h1;
	localparam logic [3:0] PWP_ADDR_WSC = 4'h2;
	localparam logic [3:0] PWP_ADDR_WUS = 4'h3;
	localparam logic [3:0] PWP_ADDR_POL_STAT = 4'h4;
	localparam logic [3:0] PWP_ADDR_WPM_BASE = 4'h8;
	// Field positions.
	localparam int PWP_CTRL_IN_EN_BIT = 0;
	localparam int PWP_CTRL_OUT_EN_BIT = 1;
	localparam int PWP_CTRL_CLK_LSB = 2;
	localparam int PWP_CTRL_PER_LSB = 5;
	localparam int PWP_PORT_WAKE_ENABLE_BIT = 0;
	localparam int PWP_ALTERNATE_STROBE_SELECT_BIT = 1;
	localparam int PWP_STAT_WIN_BIT = 8;
	localparam int PWP_STAT_ARM_BIT = 9;
	// Reset values.
	localparam logic [PWP_DEL_W-1:0] PWP_RST_DEL = 8'h00;
	localparam logic [PWP_DW-1:0] PWP_RST_RDATA = 16'h0000;
	// Pin trigger modes.
	localparam logic [2:0] PWP_MODE_OFF = 3'h0;
	localparam logic [2:0] PWP_MODE_RISE = 3'h1;
	localparam logic [2:0] PWP_MODE_FALL = 3'h2;
	localparam logic [2:0] PWP_MODE_BOTH = 3'h3;
	localparam logic [2:0] PWP_MODE_HIGH = 3'h4;
	localparam logic [2:0] PWP_MODE_LOW = 3'h5;

	typedef enum logic [1:0] {
		PWP_ST_IDLE = 2'b01,
		PWP_ST_WINDOW = 2'b10
	} pwp_poll_state_type;

	typedef struct packed {
		logic [3:0] per_sel;
		logic [2:0] clk_sel;
		logic out_en;
		logic in_en;
	} pwp_pol_ctrl_type;

	typedef struct packed {
		logic alt_strobe;
		logic port_wake_en;
	} pwp_wsc_type;

	// Register port request from software.
	typedef struct packed {
		logic [PWP_AW-1:0] addr;
		logic [PWP_DW-1:0] wdata;
		logic wr;
		logic rd;
	} pwp_bus_type;

	typedef struct packed {
		pwp_pol_ctrl_type ctrl;
		logic [PWP_DEL_W-1:0] del;
		logic armed;
		pwp_wsc_type wake_source_control;
		logic [PWP_DEL_W-1:0] count;
		pwp_poll_state_type pstate;
		logic strobe;
		logic [PWP_SYNC_W-1:0] sync1;
		logic [PWP_SYNC_W-1:0] sync2;
		logic [PWP_SYNC_W-1:0] prev;
		logic [PWP_DW-1:0] rdata;
		logic irq;
		logic wake;
		logic poll_out;
	} pwp_state_type;

	// State that no reset touches.
	typedef struct packed {
		logic [PWP_NUM_PINS-1:0] flags;
		logic [PWP_NUM_PINS-1:0][2:0] modes;
	} pwp_keep_type;
endpackage

//--- core/pwp_port_wake.sv
// Port wake flags, trigger modes and polling strobe generator.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module pwp_port_wake (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// Register port.
	input wire pwp_pkg::pwp_bus_type i_bus,
	output logic [pwp_pkg::PWP_DW-1:0] o_rdata,
	// Counter taps and wake pins, asynchronous.
	input wire logic [pwp_pkg::PWP_TAPS-1:0] i_ssc_taps,
	input wire logic [pwp_pkg::PWP_TAPS-1:0] i_sec_taps,
	input wire logic [pwp_pkg::PWP_NUM_PINS-1:0] i_wake_pins,
	// Requests and poll output.
	output logic o_wake_irq,
	output logic o_wake_req,
	output logic o_poll_out
);
	pwp_pkg::pwp_state_type state_reg;
	pwp_pkg::pwp_state_type state_next;
	pwp_pkg::pwp_keep_type keep_reg;
	pwp_pkg::pwp_keep_type keep_next;
	logic [pwp_pkg::PWP_NUM_PINS-1:0] set_vec;
	// Per-pin views used only by the checks.
	logic [pwp_pkg::PWP_NUM_PINS-1:0] level_hit;
	logic [pwp_pkg::PWP_NUM_PINS-1:0] rise_hit;
	logic [pwp_pkg::PWP_NUM_PINS-1:0] off_pins;

	function automatic logic tap_pick(input logic [7:0] taps, input logic [2:0] sel);
		tap_pick = taps[sel];
	endfunction

	function automatic logic tap_rise(input logic [7:0] now, input logic [7:0] old, input logic [2:0] sel);
		tap_rise = tap_pick(now, sel) & ~tap_pick(old, sel);
	endfunction

	always_comb
	begin
		logic [7:0] pins_now;
		logic [7:0] pins_old;
		logic clk_tick;
		logic per_tick;
		logic lvl_strobe;
		logic clr;
		logic [3:0] widx;
		pins_now = state_reg.sync2[23:16];
		pins_old = state_reg.prev[23:16];
		clk_tick = 1'b0;
		per_tick = 1'b0;
		lvl_strobe = 1'b0;
		clr = 1'b0;
		widx = 4'h0;
		state_next = state_reg;
		keep_next = keep_reg;
		set_vec = '0;
		state_next.strobe = 1'b0;
		state_next.irq = 1'b0;
		state_next.wake = 1'b0;
		state_next.rdata = pwp_pkg::PWP_RST_RDATA;
		// Two-stage synchronisers, then an edge-detect stage.
		state_next.sync1 = {i_wake_pins, i_sec_taps, i_ssc_taps}; // see RULE_21
		state_next.sync2 = state_reg.sync1;
		state_next.prev = state_reg.sync2;
		clk_tick = tap_rise(state_reg.sync2[7:0], state_reg.prev[7:0], state_reg.ctrl.clk_sel); // see RULE_02
		if (state_reg.ctrl.per_sel[3])
		begin
			per_tick = tap_rise(state_reg.sync2[15:8], state_reg.prev[15:8], state_reg.ctrl.per_sel[2:0]); // see RULE_02
		end
		else
		begin
			per_tick = tap_rise(state_reg.sync2[7:0], state_reg.prev[7:0], state_reg.ctrl.per_sel[2:0]); // see RULE_02
		end
		// Register writes.
		if (i_bus.wr)
		begin
			if (i_bus.addr == pwp_pkg::PWP_ADDR_POL_CTRL)
			begin
				state_next.ctrl = pwp_pkg::pwp_pol_ctrl_type'(i_bus.wdata[8:0]);
			end
			else if (i_bus.addr == pwp_pkg::PWP_ADDR_DELAY_RELOAD_VALUE)
			begin
				state_next.del = i_bus.wdata[pwp_pkg::PWP_DEL_W-1:0];
				state_next.armed = 1'b1; // see RULE_05
			end
			else if (i_bus.addr == pwp_pkg::PWP_ADDR_WSC)
			begin
				state_next.wake_source_control.port_wake_en = i_bus.wdata[pwp_pkg::PWP_PORT_WAKE_ENABLE_BIT];
				state_next.wake_source_control.alt_strobe = i_bus.wdata[pwp_pkg::PWP_ALTERNATE_STROBE_SELECT_BIT];
			end
			else if (i_bus.addr == pwp_pkg::PWP_ADDR_WUS)
			begin
				clr = 1'b1; // see RULE_19
			end
			else if (i_bus.addr >= pwp_pkg::PWP_ADDR_WPM_BASE)
			begin
				widx = i_bus.addr - pwp_pkg::PWP_ADDR_WPM_BASE;
				keep_next.modes[widx[2:0]] = i_bus.wdata[2:0];
			end
		end
		// Register reads, data valid the cycle after the strobe only.
		if (i_bus.rd)
		begin
			if (i_bus.addr == pwp_pkg::PWP_ADDR_POL_CTRL)
			begin
				state_next.rdata = {7'h00, state_reg.ctrl};
			end
			else if (i_bus.addr == pwp_pkg::PWP_ADDR_DELAY_RELOAD_VALUE)
			begin
				state_next.rdata = {8'h00, state_reg.del};
			end
			else if (i_bus.addr == pwp_pkg::PWP_ADDR_WSC)
			begin
				state_next.rdata = {14'h0000, state_reg.wake_source_control};
			end
			else if (i_bus.addr == pwp_pkg::PWP_ADDR_WUS)
			begin
				state_next.rdata = {8'h00, keep_reg.flags}; // see RULE_16
			end
			else if (i_bus.addr == pwp_pkg::PWP_ADDR_POL_STAT)
			begin
				state_next.rdata = {6'h00, state_reg.armed, state_reg.pstate == pwp_pkg::PWP_ST_WINDOW, state_reg.count};
			end
			else if (i_bus.addr >= pwp_pkg::PWP_ADDR_WPM_BASE)
			begin
				widx = i_bus.addr - pwp_pkg::PWP_ADDR_WPM_BASE;
				state_next.rdata = {13'h0000, keep_reg.modes[widx[2:0]]};
			end
		end
		// Polling window.
		case (state_reg.pstate)
			pwp_pkg::PWP_ST_IDLE:
			begin
				if (per_tick && state_reg.ctrl.in_en && state_reg.armed && state_reg.del != 8'h00)
				begin
					state_next.count = state_reg.del; // see RULE_20
					state_next.pstate = pwp_pkg::PWP_ST_WINDOW;
				end
			end
			pwp_pkg::PWP_ST_WINDOW:
			begin
				if (clk_tick)
				begin
					state_next.count = state_reg.count - 8'h01; // see RULE_20
					if (state_reg.count == 8'h01)
					begin
						state_next.pstate = pwp_pkg::PWP_ST_IDLE;
						state_next.strobe = state_reg.ctrl.in_en; // see RULE_08
					end
				end
			end
			default:
			begin
				state_next.pstate = pwp_pkg::PWP_ST_IDLE;
			end
		endcase
		// Clearing both enables stops polling and disarms the reload.
		if (!state_next.ctrl.in_en && !state_next.ctrl.out_en)
		begin
			state_next.pstate = pwp_pkg::PWP_ST_IDLE; // see RULE_04
			state_next.count = 8'h00;
			state_next.armed = 1'b0; // see RULE_05
			state_next.strobe = 1'b0;
		end
		state_next.poll_out = state_next.ctrl.out_en && state_next.pstate == pwp_pkg::PWP_ST_WINDOW;
		// One strobe source for all level modes.
		lvl_strobe = state_reg.wake_source_control.alt_strobe | state_reg.strobe; // see RULE_11
		for (int i = 0; i < pwp_pkg::PWP_NUM_PINS; i++)
		begin
			case (keep_reg.modes[i])
				pwp_pkg::PWP_MODE_RISE: set_vec[i] = pins_now[i] & ~pins_old[i]; // see RULE_12
				pwp_pkg::PWP_MODE_FALL: set_vec[i] = ~pins_now[i] & pins_old[i]; // see RULE_12
				pwp_pkg::PWP_MODE_BOTH: set_vec[i] = pins_now[i] ^ pins_old[i]; // see RULE_12
				pwp_pkg::PWP_MODE_HIGH: set_vec[i] = lvl_strobe & pins_now[i]; // see RULE_08
				pwp_pkg::PWP_MODE_LOW: set_vec[i] = lvl_strobe & ~pins_now[i]; // see RULE_08
				default: set_vec[i] = 1'b0; // see RULE_07
			endcase
			// A set in the same cycle as a clear wins, which also holds alternate-strobe flags.
			keep_next.flags[i] = set_vec[i] | (keep_reg.flags[i] & ~(clr & i_bus.wdata[i])); // see RULE_09
		end
		// New requests only when no flag is pending.
		if (keep_reg.flags == 8'h00 && set_vec != 8'h00) // see RULE_14
		begin
			state_next.irq = 1'b1; // see RULE_15
			state_next.wake = state_reg.wake_source_control.port_wake_en; // see RULE_13
		end
	end

	// Polling and bus state, cleared by every reset.
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_reg <= '{ctrl: '0, del: pwp_pkg::PWP_RST_DEL, armed: 1'b0, wake_source_control: '0, count: 8'h00,
				pstate: pwp_pkg::PWP_ST_IDLE, strobe: 1'b0, sync1: '0, sync2: '0, prev: '0,
				rdata: pwp_pkg::PWP_RST_RDATA, irq: 1'b0, wake: 1'b0, poll_out: 1'b0}; // see RULE_01
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// Flags and modes deliberately have no reset.
	always_ff @(posedge i_clk_sys)
	begin
		keep_reg <= keep_next; // see RULE_06
	end

	// Checks cover every pin, so the randomly chosen pins of a test are always watched.
	always_comb
	begin
		level_hit = '0;
		rise_hit = '0;
		off_pins = '0;
		for (int i = 0; i < pwp_pkg::PWP_NUM_PINS; i++)
		begin
			level_hit[i] = (keep_reg.modes[i] == pwp_pkg::PWP_MODE_HIGH && state_reg.sync2[2 * pwp_pkg::PWP_TAPS + i])
				|| (keep_reg.modes[i] == pwp_pkg::PWP_MODE_LOW && !state_reg.sync2[2 * pwp_pkg::PWP_TAPS + i]);
			rise_hit[i] = keep_reg.modes[i] == pwp_pkg::PWP_MODE_RISE && state_reg.sync2[2 * pwp_pkg::PWP_TAPS + i]
				&& !state_reg.prev[2 * pwp_pkg::PWP_TAPS + i];
			off_pins[i] = keep_reg.modes[i] == pwp_pkg::PWP_MODE_OFF
				|| keep_reg.modes[i] > pwp_pkg::PWP_MODE_LOW;
		end
	end

	assign o_rdata = state_reg.rdata;
	assign o_wake_irq = state_reg.irq;
	assign o_wake_req = state_reg.wake;
	assign o_poll_out = state_reg.poll_out;

	property p_rst_idle;
		@(posedge i_clk_sys) $rose(i_rst_b) |-> state_reg.pstate == pwp_pkg::PWP_ST_IDLE && !o_poll_out;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("Polling not idle after reset."); // see RULE_01

	property p_off_quiet;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		(set_vec & off_pins) == 8'h00;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("Disabled pin produced a wake event."); // see RULE_07

	property p_fall_strobe;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		state_reg.strobe |-> $past(state_reg.pstate) == pwp_pkg::PWP_ST_WINDOW
			&& state_reg.pstate == pwp_pkg::PWP_ST_IDLE;
	endproperty
	a_fall_strobe: assert property (p_fall_strobe) else $error("Strobe not at window fall."); // see RULE_08

	property p_alt_hold;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		state_reg.wake_source_control.alt_strobe && level_hit != 8'h00
			|=> (keep_reg.flags & $past(level_hit)) == $past(level_hit);
	endproperty
	a_alt_hold: assert property (p_alt_hold) else $error("Alternate-strobe flag was cleared."); // see RULE_09

	property p_wake_gate;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_wake_req |-> $past(state_reg.wake_source_control.port_wake_en) && o_wake_irq;
	endproperty
	a_wake_gate: assert property (p_wake_gate) else $error("Wake request without port wake enable."); // see RULE_13

	property p_pending_block;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_wake_irq |-> $past(keep_reg.flags) == 8'h00 ##1 !o_wake_irq;
	endproperty
	a_pending_block: assert property (p_pending_block) else $error("Interrupt while a flag was pending."); // see RULE_14

	property p_edge_set;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		rise_hit != 8'h00 |=> (keep_reg.flags & $past(rise_hit)) == $past(rise_hit);
	endproperty
	a_edge_set: assert property (p_edge_set) else $error("Rising edge did not set the flag."); // see RULE_12

	property p_stop;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		!state_reg.ctrl.in_en && !state_reg.ctrl.out_en |-> !state_reg.armed && !o_poll_out
			&& state_reg.pstate == pwp_pkg::PWP_ST_IDLE;
	endproperty
	a_stop: assert property (p_stop) else $error("Polling active with both enables clear."); // see RULE_04

	property p_window_load;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		$rose(state_reg.pstate == pwp_pkg::PWP_ST_WINDOW) |-> state_reg.count == $past(state_reg.del)
			&& state_reg.count != 8'h00;
	endproperty
	a_window_load: assert property (p_window_load) else $error("Window not loaded from reload value."); // see RULE_20

	property p_irq_source;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_wake_irq |-> keep_reg.flags != 8'h00;
	endproperty
	a_irq_source: assert property (p_irq_source) else $error("Interrupt with no source flag."); // see RULE_15

	property p_req_single;
		@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_wake_req |=> !o_wake_req;
	endproperty
	a_req_single: assert property (p_req_single) else $error("Repeated wake request while flags pending."); // see RULE_14

	c_window: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) $rose(o_poll_out));
	c_strobe_set: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) state_reg.strobe && set_vec != 8'h00);
	c_wake: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) o_wake_req);
	c_edge: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) rise_hit != 8'h00);
	c_alt: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) state_reg.wake_source_control.alt_strobe && i_bus.wr
		&& i_bus.addr == pwp_pkg::PWP_ADDR_WUS && set_vec != 8'h00);
endmodule

//--- sim/pwp_pin_model.sv
// Far-side model: free-running counter taps and wake pin levels.
`timescale 1ns/1ps
module pwp_pin_model (
	// Clock.
	input wire logic i_clk_sys,
	// Counter taps and wake pins.
	output logic [pwp_pkg::PWP_TAPS-1:0] o_ssc_taps,
	output logic [pwp_pkg::PWP_TAPS-1:0] o_sec_taps,
	output logic [pwp_pkg::PWP_NUM_PINS-1:0] o_wake_pins
);
	initial
	begin
		o_ssc_taps = 8'h00;
		o_sec_taps = 8'h00;
		o_wake_pins = 8'h00;
	end
	// The counters run free whether polling is enabled or not.
	always @(posedge i_clk_sys)
	begin
		o_ssc_taps <= o_ssc_taps + 8'h01;
		if (o_ssc_taps == 8'hFF)
			o_sec_taps <= o_sec_taps + 8'h01;
	end
	task automatic set_pin(input int idx, input logic lvl);
		@(posedge i_clk_sys);
		o_wake_pins[idx] <= lvl;
	endtask
endmodule

//--- sim/pwp_port_wake_tb_top.sv
// Self-checking testbench for the port wake and polling block.
`timescale 1ns/1ps
module pwp_port_wake_tb_top;
	logic i_clk_sys;
	logic i_rst_b;
	pwp_pkg::pwp_bus_type bus;
	logic [15:0] o_rdata;
	logic [7:0] sub_second_counter;
	logic [7:0] sec;
	logic [7:0] pins;
	logic o_wake_irq;
	logic o_wake_req;
	logic o_poll_out;
	logic rd_d;
	logic [15:0] exp_q[$];
	int error_cnt;
	int checks_done;
	int irq_cnt;
	int req_cnt;
	int poll_hi;
	int cyc;
	int k;
	int m;
	int dly;
	int poll_base;

	pwp_port_wake pwp_port_wake_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_bus(bus), .o_rdata(o_rdata),
		.i_ssc_taps(sub_second_counter), .i_sec_taps(sec), .i_wake_pins(pins), .o_wake_irq(o_wake_irq),
		.o_wake_req(o_wake_req), .o_poll_out(o_poll_out));
	pwp_pin_model pwp_pin_model_inst (.i_clk_sys(i_clk_sys), .o_ssc_taps(sub_second_counter), .o_sec_taps(sec),
		.o_wake_pins(pins));

	initial
	begin
		i_clk_sys = 1'b0;
		forever
			#5 i_clk_sys = ~i_clk_sys;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Read data are compared in the cycle after the read strobe, against the oldest note.
	always @(posedge i_clk_sys)
	begin
		rd_d <= bus.rd;
		if (rd_d === 1'b1)
			check(o_rdata, exp_q.pop_front());
		if (o_wake_irq === 1'b1)
			irq_cnt++;
		if (o_wake_req === 1'b1)
			req_cnt++;
		if (o_poll_out === 1'b1)
			poll_hi++;
		cyc++;
		if (cyc == 6000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk_sys);
		bus.wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		@(posedge i_clk_sys);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge i_clk_sys);
		bus.rd <= 1'b0;
	endtask

	task automatic pin(input int i, input logic v);
		pwp_pin_model_inst.set_pin(i, v);
		repeat (8) @(posedge i_clk_sys);
	endtask

	task automatic mode(input int i, input logic [2:0] md);
		reg_wr(pwp_pkg::PWP_ADDR_WPM_BASE + 4'(i), {13'h0000, md});
	endtask

	task automatic wait_poll(input logic lvl);
		int n;
		n = 0;
		while (o_poll_out !== lvl && n < 400)
		begin
			@(posedge i_clk_sys);
			n++;
		end
		check({15'h0000, o_poll_out}, {15'h0000, lvl});
	endtask

	initial
	begin
		i_rst_b = 1'b0;
		bus = '0;
		rd_d = 1'b0;
		error_cnt = 0;
		checks_done = 0;
		cyc = 0;
		void'($urandom(92577));
		repeat (16) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		for (int i = 0; i < 8; i++)
			mode(i, pwp_pkg::PWP_MODE_OFF);
		reg_wr(pwp_pkg::PWP_ADDR_WUS, 16'hFFFF);
		reg_rd(4'h5, 16'h0000);
		reg_rd(pwp_pkg::PWP_ADDR_POL_CTRL, 16'h0000);
		irq_cnt = 0;
		req_cnt = 0;
		$display("test init done");
		k = $urandom % 8;
		m = (k + 1) % 8;
		mode(k, pwp_pkg::PWP_MODE_RISE);
		mode(m, pwp_pkg::PWP_MODE_FALL);
		pin(m, 1'b1);
		pin(k, 1'b1);
		check(16'(irq_cnt), 16'h0001);
		check(16'(req_cnt), 16'h0000);
		reg_rd(pwp_pkg::PWP_ADDR_WUS, 16'(1 << k));
		pin(m, 1'b0);
		check(16'(irq_cnt), 16'h0001);
		reg_rd(pwp_pkg::PWP_ADDR_WUS, 16'((1 << k) | (1 << m)));
		reg_wr(pwp_pkg::PWP_ADDR_WUS, 16'hFFFF);
		reg_rd(pwp_pkg::PWP_ADDR_WUS, 16'h0000);
		reg_wr(pwp_pkg::PWP_ADDR_WSC, 16'h0001);
		mode(k, pwp_pkg::PWP_MODE_BOTH);
		pin(k, 1'b0);
		check(16'(irq_cnt), 16'h0002);
		check(16'(req_cnt), 16'h0001);
		reg_wr(pwp_pkg::PWP_ADDR_WUS, 16'hFFFF);
		mode(k, pwp_pkg::PWP_MODE_OFF);
		pin(k, 1'b1);
		reg_rd(pwp_pkg::PWP_ADDR_WUS, 16'h0000);
		check(16'(irq_cnt), 16'h0002);
		$display("test edge done");
		reg_wr(pwp_pkg::PWP_ADDR_WSC, 16'h0002);
		mode(k, pwp_pkg::PWP_MODE_HIGH);
		repeat (4) @(posedge i_clk_sys);
		reg_wr(pwp_pkg::PWP_ADDR_WUS, 16'hFFFF);
		reg_rd(pwp_pkg::PWP_ADDR_WUS, 16'(1 << k));
		mode(k, pwp_pkg::PWP_MODE_OFF);
		reg_wr(pwp_pkg::PWP_ADDR_WUS, 16'hFFFF);
		reg_rd(pwp_pkg::PWP_ADDR_WUS, 16'h0000);
		pin(k, 1'b0);
		mode(k, pwp_pkg::PWP_MODE_HIGH);
		pwp_pin_model_inst.set_pin(k, 1'b1);
		pin(k, 1'b0);
		reg_rd(pwp_pkg::PWP_ADDR_WUS, 16'(1 << k));
		mode(k, pwp_pkg::PWP_MODE_OFF);
		reg_wr(pwp_pkg::PWP_ADDR_WUS, 16'hFFFF);
		$display("test alternate strobe done");
		reg_wr(pwp_pkg::PWP_ADDR_WSC, 16'h0000);
		mode(m, pwp_pkg::PWP_MODE_LOW);
		repeat (40) @(posedge i_clk_sys);
		reg_rd(pwp_pkg::PWP_ADDR_WUS, 16'h0000);
		reg_wr(pwp_pkg::PWP_ADDR_POL_CTRL, 16'h0084);
		check({15'h0000, o_poll_out}, 16'h0000);
		reg_wr(pwp_pkg::PWP_ADDR_POL_CTRL, 16'h0087);
		dly = 3 + $urandom % 6;
		reg_wr(pwp_pkg::PWP_ADDR_DELAY_RELOAD_VALUE, 16'(dly));
		poll_base = poll_hi;
		wait_poll(1'b1);
		reg_rd(pwp_pkg::PWP_ADDR_WUS, 16'h0000);
		wait_poll(1'b0);
		check(16'(poll_hi - poll_base >= 4 * (dly - 1) && poll_hi - poll_base <= 4 * dly), 16'h0001);
		repeat (4) @(posedge i_clk_sys);
		reg_rd(pwp_pkg::PWP_ADDR_WUS, 16'(1 << m));
		reg_wr(pwp_pkg::PWP_ADDR_POL_CTRL, 16'h0084);
		@(posedge i_clk_sys);
		poll_base = poll_hi;
		repeat (100) @(posedge i_clk_sys);
		check(16'(poll_hi - poll_base), 16'h0000);
		reg_wr(pwp_pkg::PWP_ADDR_POL_CTRL, 16'h0087);
		reg_wr(pwp_pkg::PWP_ADDR_DELAY_RELOAD_VALUE, 16'h0003);
		wait_poll(1'b1);
		reg_wr(pwp_pkg::PWP_ADDR_POL_CTRL, 16'h0084);
		$display("test polling done");
		@(posedge i_clk_sys);
		i_rst_b <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		reg_rd(pwp_pkg::PWP_ADDR_WUS, 16'(1 << m));
		reg_rd(pwp_pkg::PWP_ADDR_POL_CTRL, 16'h0000);
		reg_rd(pwp_pkg::PWP_ADDR_DELAY_RELOAD_VALUE, 16'h0000);
		repeat (4) @(posedge i_clk_sys);
		$display("test reset done");
		report_and_stop();
	end
endmodule
